// ==== rsb_consts.vh ====
// Purpose: Constants for the reset strap capture and boot select block.
// Assumes: Straps are stable while power-on reset is asserted.
// Notes: Boot codes follow the four-entry boot table.
//
// Contract
// RQ1: All strap inputs are latched when power-on reset is released.
// RQ2: Boot code 00 selects host-port boot with the PLL left disabled.
// RQ3: Boot code 01 selects program download over the I2C port.
// RQ4: Boot code 10 selects host-port boot with PLL enabled; 11 is reserved.
// RQ5: Strobe-polarity strap 0 gives active-low strobes, 1 active-high.
// RQ6: Width strap 0 gives a 16-bit host path, 1 an 8-bit path.
// RQ7: After power-on reset the PLL is bypassed until software enables it; code enables it at boot for code 10 with no software request.
// RQ8: The core runs the internal ROM boot loader after any reset; code starts it only after power-on release or a later hard reset.
// RQ9: Host-port boot runs without DMA and in polled mode on both sides.
// RQ10: The host writes boot data four 16-bit words at a time, MSW first.
// RQ11: Width and strobe straps are sampled only at power-on reset release.
// RQ12: Host data bit 0 is the least significant bit of every word.
// RQ13: Watchdog strap 0 disables the watchdog, 1 enables it.
// RQ14: I2C boot switches shared pins to I2C with the device as master.
// RQ15: Latched straps stay stable until the next power-on reset; code also clears them on rst_b.
`ifndef RSB_CONSTS_VH
`define RSB_CONSTS_VH
`define RSB_BOOT_HOST_NOPLL 2'h0
`define RSB_BOOT_I2C 2'h1
`define RSB_BOOT_HOST_PLL 2'h2
`define RSB_BOOT_RSVD 2'h3
`define RSB_WIDTH_16 1'h0
`define RSB_POL_LOW 1'h0
// One-hot sequencer states
`define RSB_ST_HOLD 4'h1
`define RSB_ST_CAPT 4'h2
`define RSB_ST_BOOT 4'h4
`define RSB_ST_RUN 4'h8
`endif

// ==== rsb_sync_edge.v ====
// Purpose: Synchronise a reset level and flag its release.
// Assumes: Level may be asynchronous to clk_sys.
// Notes: First stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none
module rsb_sync_edge (
    input wire clk_sys, // System clock
    input wire rst_b, // Async reset, active low
    input wire level_in, // Raw level
    output reg level_q, // Synchronised level
    output reg rise_q // One-cycle pulse on rising edge
);
    reg meta_q;
    reg prev_q;
    // Clear to the released level: a pin already high at rst_b release
    // must not look like a fresh rising edge
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= 1'b1;
            level_q <= 1'b1;
            prev_q <= 1'b1;
            rise_q <= 1'b0;
        end else begin
            meta_q <= level_in;
            level_q <= meta_q;
            prev_q <= level_q;
            rise_q <= level_q & ~prev_q;
        end
    end
endmodule // rsb_sync_edge
`default_nettype wire

// ==== rsb_reset_boot.v ====
// Purpose: Capture straps at power-on reset release and select boot path.
// Assumes: Straps are static while power-on reset is low.
// Notes: All outputs are registered.
`include "rsb_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module rsb_reset_boot (
    input wire clk_sys, // System clock, 125 MHz
    input wire rst_b, // Async reset, active low
    input wire power_on_reset_n, // Power-on reset, active low
    input wire hard_reset_n, // Hard reset, active low
    input wire [1:0] boot_select_straps, // Boot mode straps
    input wire watchdog_enable_strap, // Watchdog enable strap
    input wire host_strobe_polarity_strap, // Strobe polarity strap
    input wire host_width_strap, // Host width strap
    input wire host_dual_strobe_strap, // Dual strobe strap
    input wire pll_enable_req, // Software PLL enable, level
    output reg [1:0] boot_mode_q, // Latched boot code
    output reg boot_host_q, // Host-port boot selected
    output reg boot_i2c_q, // I2C boot selected
    output reg boot_reserved_q, // Reserved code latched
    output reg pll_enable_q, // PLL in use; low means bypass
    output reg host_8bit_q, // Host path 8-bit
    output reg host_strobe_high_q, // Strobes active high
    output reg host_dual_strobe_q, // Dual strobe mode
    output reg host_dma_enable_q, // Host DMA allowed
    output reg host_polled_q, // Host polled mode
    output reg host_lsb_bit0_q, // Bit 0 is word LSB
    output reg i2c_pins_sel_q, // Shared pins to I2C
    output reg i2c_master_q, // I2C acts as master
    output reg watchdog_enable_q, // Watchdog enabled
    output reg core_reset_n_q, // Core reset, active low
    output reg rom_boot_start_q, // Pulse: start ROM loader
    output reg straps_valid_q // Straps latched
);
    localparam [3:0] ST_HOLD = `RSB_ST_HOLD;
    localparam [3:0] ST_CAPT = `RSB_ST_CAPT;
    localparam [3:0] ST_BOOT = `RSB_ST_BOOT;
    localparam [3:0] ST_RUN = `RSB_ST_RUN;

    wire por_lvl;
    wire por_rise;
    wire hrst_lvl;
    wire hrst_rise;
    reg [3:0] state_q;
    reg [3:0] state_d;
    reg por_seen_q;

    // Host-port boot decode, used for both host codes
    function is_host_boot;
        input [1:0] code;
        begin
            is_host_boot = (code == `RSB_BOOT_HOST_NOPLL) ||
                (code == `RSB_BOOT_HOST_PLL);
        end
    endfunction

    rsb_sync_edge u_por_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .level_in(power_on_reset_n),
        .level_q(por_lvl),
        .rise_q(por_rise)
    );

    rsb_sync_edge u_hrst_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .level_in(hard_reset_n),
        .level_q(hrst_lvl),
        .rise_q(hrst_rise)
    );

    always @* begin
        state_d = state_q;
        case (state_q)
            ST_HOLD: begin
                if (por_rise)
                    state_d = ST_CAPT;
                else if (hrst_rise && por_seen_q)
                    state_d = ST_BOOT;
            end
            ST_CAPT: begin
                state_d = ST_BOOT;
            end
            ST_BOOT: begin
                state_d = ST_RUN;
            end
            ST_RUN: begin
                if (!por_lvl || !hrst_lvl)
                    state_d = ST_HOLD;
            end
            default: begin
                state_d = ST_HOLD;
            end
        endcase
        if (!por_lvl)
            state_d = ST_HOLD;
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_HOLD;
            por_seen_q <= 1'b0;
            boot_mode_q <= `RSB_BOOT_HOST_NOPLL;
            boot_host_q <= 1'b0;
            boot_i2c_q <= 1'b0;
            boot_reserved_q <= 1'b0;
            pll_enable_q <= 1'b0;
            host_8bit_q <= 1'b0;
            host_strobe_high_q <= 1'b0;
            host_dual_strobe_q <= 1'b0;
            host_dma_enable_q <= 1'b0;
            host_polled_q <= 1'b0;
            host_lsb_bit0_q <= 1'b1;
            i2c_pins_sel_q <= 1'b0;
            i2c_master_q <= 1'b0;
            watchdog_enable_q <= 1'b0;
            core_reset_n_q <= 1'b0;
            rom_boot_start_q <= 1'b0;
            straps_valid_q <= 1'b0;
        end else begin
            state_q <= state_d;
            rom_boot_start_q <= 1'b0;
            host_lsb_bit0_q <= 1'b1; // [RQ12]
            // Straps are caught only on the power-on release edge
            if (por_rise) begin
                por_seen_q <= 1'b1;
                straps_valid_q <= 1'b1;
                boot_mode_q <= boot_select_straps; // [RQ1]
                watchdog_enable_q <= watchdog_enable_strap; // [RQ1] [RQ13]
                host_8bit_q <= (host_width_strap != `RSB_WIDTH_16); // [RQ6] [RQ11]
                host_strobe_high_q <=
                    (host_strobe_polarity_strap != `RSB_POL_LOW); // [RQ5] [RQ11]
                host_dual_strobe_q <= host_dual_strobe_strap; // [RQ11]
            end
            // Hard reset keeps latched straps; only core is restarted
            if (!por_lvl) begin
                straps_valid_q <= 1'b0; // [RQ15]
                pll_enable_q <= 1'b0; // [RQ7]
                core_reset_n_q <= 1'b0;
                i2c_pins_sel_q <= 1'b0;
                i2c_master_q <= 1'b0;
                host_polled_q <= 1'b0;
                host_dma_enable_q <= 1'b0;
                boot_host_q <= 1'b0;
                boot_i2c_q <= 1'b0;
                boot_reserved_q <= 1'b0;
            end else if (!hrst_lvl) begin
                core_reset_n_q <= 1'b0;
            end else begin
                case (state_q)
                    ST_BOOT: begin
                        core_reset_n_q <= 1'b1;
                        rom_boot_start_q <= 1'b1; // [RQ8]
                        boot_host_q <= is_host_boot(boot_mode_q); // [RQ2] [RQ4]
                        boot_i2c_q <= (boot_mode_q == `RSB_BOOT_I2C); // [RQ3]
                        boot_reserved_q <=
                            (boot_mode_q == `RSB_BOOT_RSVD); // [RQ4]
                        // Polled, no DMA during host boot
                        host_polled_q <= is_host_boot(boot_mode_q); // [RQ9]
                        host_dma_enable_q <= 1'b0; // [RQ9]
                        i2c_pins_sel_q <= (boot_mode_q == `RSB_BOOT_I2C); // [RQ14]
                        i2c_master_q <= (boot_mode_q == `RSB_BOOT_I2C); // [RQ14]
                        // Only code 10 enables the PLL for boot
                        pll_enable_q <=
                            (boot_mode_q == `RSB_BOOT_HOST_PLL); // [RQ2] [RQ4] [RQ7]
                    end
                    ST_RUN: begin
                        if (pll_enable_req)
                            pll_enable_q <= 1'b1; // [RQ7]
                        if (!boot_host_q)
                            host_polled_q <= 1'b0;
                    end
                    default: begin
                        core_reset_n_q <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule // rsb_reset_boot
`default_nettype wire

// ==== rsb_reset_boot_props.sv ====
// Purpose: Checker for strap capture and boot select
// Assumes: Bound to rsb_reset_boot
// Notes: Sees top ports only
`timescale 1ns/1ps
`default_nettype none
module rsb_props (
    input wire logic clk_sys, // Clock
    input wire logic rst_b, // Reset
    input wire logic [1:0] boot_select_straps, // Pins
    input wire logic host_strobe_polarity_strap, // Pin
    input wire logic host_width_strap, // Pin
    input wire logic [1:0] boot_mode_q, // Out
    input wire logic boot_host_q, // Out
    input wire logic boot_i2c_q, // Out
    input wire logic boot_reserved_q, // Out
    input wire logic pll_enable_q, // Out
    input wire logic host_8bit_q, // Out
    input wire logic host_strobe_high_q, // Out
    input wire logic host_dma_enable_q, // Out
    input wire logic host_polled_q, // Out
    input wire logic i2c_master_q, // Out
    input wire logic core_reset_n_q, // Out
    input wire logic rom_boot_start_q, // Out
    input wire logic straps_valid_q // Out
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    AST_CAPT: assert property ($rose(straps_valid_q) |->
        boot_mode_q == $past(boot_select_straps)) else $error("capture");
    AST_POL: assert property ($rose(straps_valid_q) |->
        host_strobe_high_q == $past(host_strobe_polarity_strap))
        else $error("polarity");
    AST_WID: assert property ($rose(straps_valid_q) |->
        host_8bit_q == $past(host_width_strap)) else $error("width");
    AST_BYP: assert property ($rose(straps_valid_q) |->
        !pll_enable_q) else $error("pll not bypassed");
    AST_SEQ: assert property ($rose(straps_valid_q) |-> ##2
        core_reset_n_q && rom_boot_start_q ##1 !rom_boot_start_q)
        else $error("loader start");
    AST_DEC: assert property (rom_boot_start_q |->
        boot_host_q == !boot_mode_q[0] && boot_i2c_q == (boot_mode_q == 2'h1)
        && boot_reserved_q == (boot_mode_q == 2'h3)) else $error("decode");
    AST_HOST: assert property (boot_host_q |->
        host_polled_q && !host_dma_enable_q) else $error("host mode");
    AST_I2C: assert property (boot_i2c_q |-> i2c_master_q)
        else $error("i2c master");
    AST_HLD: assert property (straps_valid_q ##1 straps_valid_q |->
        $stable({boot_mode_q, host_8bit_q, host_strobe_high_q}))
        else $error("straps moved");
    cover property (boot_i2c_q && rom_boot_start_q);
    cover property (boot_reserved_q && rom_boot_start_q);
    cover property ($fell(core_reset_n_q) && straps_valid_q);
endmodule // rsb_props
bind rsb_reset_boot rsb_props u_props (.*);
`default_nettype wire

// ==== rsb_strap_board.sv ====
// Purpose: Board straps behind the device pins
// Assumes: Straps held only a few cycles past release
// Notes: Host word order is the host's own duty
`timescale 1ns/1ps
`default_nettype none
module rsb_strap_board (
    input wire logic clk_sys, // Clock
    input wire logic power_on_reset_n, // Power-on reset
    input wire logic [5:0] cfg, // Wanted levels
    output wire logic [5:0] straps // Strap pins
);
    logic [3:0] cnt_q = 4'h0;
    always @(posedge clk_sys) begin
        if (!power_on_reset_n) cnt_q <= 4'h0;
        else if (cnt_q != 4'hf) cnt_q <= cnt_q + 4'h1;
    end
    // Floating pins shown inverted so a late sample is caught
    assign straps = (!power_on_reset_n || cnt_q < 4'h6) ? cfg : ~cfg;
endmodule // rsb_strap_board
`default_nettype wire

// ==== rsb_reset_boot_tb_top.sv ====
// Purpose: Self-checking bench for strap capture and boot select
// Assumes: Board model floats straps after hold time
// Notes: Rows cover all four boot codes
`timescale 1ns/1ps
`default_nettype none
module rsb_reset_boot_tb_top;
    logic clk_sys, rst_b, por_n, hrst_n, pll_req;
    logic [5:0] cfg;
    wire logic [5:0] s;
    wire logic [12:0] o;
    wire logic start;
    wire logic [3:0] x;
    int err_count, total_checks, r;
    // Row: {code, watchdog, polarity, width, dual}
    logic [5:0] row_cfg [4] = '{6'h0a, 6'h15, 6'h2f, 6'h30};
    // Row: {code, host, i2c, rsvd, pll, 8bit, high, dual, wdog, core, valid, lsb}
    logic [12:0] row_exp [4] = '{13'h044f, 13'h0a37, 13'h14ff, 13'h1907};
    // Row: {dma, polled, i2c pins, i2c master}
    logic [3:0] row_path [4] = '{4'h4, 4'h3, 4'h4, 4'h0};
    rsb_strap_board u_board (.clk_sys(clk_sys), .power_on_reset_n(por_n),
        .cfg(cfg), .straps(s));
    rsb_reset_boot u_dut (.clk_sys(clk_sys), .rst_b(rst_b),
        .power_on_reset_n(por_n), .hard_reset_n(hrst_n),
        .boot_select_straps(s[5:4]), .watchdog_enable_strap(s[3]),
        .host_strobe_polarity_strap(s[2]), .host_width_strap(s[1]),
        .host_dual_strobe_strap(s[0]), .pll_enable_req(pll_req),
        .boot_mode_q(o[12:11]), .boot_host_q(o[10]), .boot_i2c_q(o[9]),
        .boot_reserved_q(o[8]), .pll_enable_q(o[7]), .host_8bit_q(o[6]),
        .host_strobe_high_q(o[5]), .host_dual_strobe_q(o[4]),
        .watchdog_enable_q(o[3]), .core_reset_n_q(o[2]),
        .straps_valid_q(o[1]), .host_lsb_bit0_q(o[0]),
        .rom_boot_start_q(start), .host_dma_enable_q(x[3]),
        .host_polled_q(x[2]), .i2c_pins_sel_q(x[1]), .i2c_master_q(x[0]));
    task automatic chk(input string n, input logic [12:0] v, e);
        total_checks++;
        if (v !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, e, v);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic wait_start();
        for (int k = 0; k < 20 && start !== 1'b1; k++) cyc(1);
        chk("loader start", {12'h000, start}, 13'h0001);
    endtask
    task automatic close_out();
        if (err_count == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        rst_b = 1'b0;
        por_n = 1'b0;
        hrst_n = 1'b1;
        pll_req = 1'b0;
        cfg = 6'h00;
        cyc(8);
        chk("reset", o, 13'h0001);
        rst_b = 1'b1;
        for (r = 0; r < 4; r++) begin
            cfg = row_cfg[r];
            por_n = 1'b0;
            cyc(4);
            por_n = 1'b1;
            wait_start();
            cyc(4);
            chk("boot row", o, row_exp[r]);
            chk("boot path", {9'h000, x}, {9'h000, row_path[r]});
        end
        pll_req = 1'b1;
        cyc(2);
        chk("pll enable", o, 13'h1987);
        hrst_n = 1'b0;
        cyc(6);
        chk("in hard reset", o, 13'h1983);
        hrst_n = 1'b1;
        wait_start();
        cyc(2);
        chk("after hard reset", o, 13'h1987);
        rst_b = 1'b0;
        cyc(2);
        chk("mid reset", o, 13'h0001);
        rst_b = 1'b1;
        cyc(8);
        chk("no power-on edge", o, 13'h0001);
        hrst_n = 1'b0;
        cyc(4);
        hrst_n = 1'b1;
        cyc(8);
        chk("hard reset only", o, 13'h0001);
        close_out();
    end
    initial begin
        #16000;
        err_count++;
        close_out();
    end
endmodule // rsb_reset_boot_tb_top
`default_nettype wire
